// >>> verilog/ipr_pkg.sv
// Constants for the capture, ADC and external interrupt priority register slice.
package ipr_pkg;

   // ----------------------------------------------------------------
   // Register map and bus widths.
   // ----------------------------------------------------------------
   localparam int unsigned IPR_ADDR_W = 8;
   localparam int unsigned IPR_DATA_W = 16;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFF_PRIORITY = 8'h00;

   // ----------------------------------------------------------------
   // Field layout: four 3-bit fields, one every four bits.
   // ----------------------------------------------------------------
   localparam int unsigned IPR_NUM_FIELDS = 4;
   localparam int unsigned IPR_FIELD_W = 3;
   localparam int unsigned IPR_FIELD_STRIDE = 4;
   localparam int unsigned IPR_IDX_EXT1 = 0;
   localparam int unsigned IPR_IDX_ADC2 = 1;
   localparam int unsigned IPR_IDX_CAPTURE7 = 2;
   localparam int unsigned IPR_IDX_CAPTURE8 = 3;
   localparam int unsigned IPR_LSB_EXT1 = 0;
   localparam int unsigned IPR_LSB_ADC2 = 4;
   localparam int unsigned IPR_LSB_CAPTURE7 = 8;
   localparam int unsigned IPR_LSB_CAPTURE8 = 12;

   // ----------------------------------------------------------------
   // Values: reset level, disabled level, masks of the view.
   // ----------------------------------------------------------------
   localparam logic [IPR_FIELD_W-1:0] IPR_LEVEL_RESET = 3'h4;
   localparam logic [IPR_FIELD_W-1:0] IPR_LEVEL_OFF = 3'h0;
   localparam logic [IPR_DATA_W-1:0] IPR_IMPL_MASK = 16'h7777;
   localparam logic [IPR_DATA_W-1:0] IPR_UNIMPL_MASK = 16'h8888;
   localparam logic [IPR_DATA_W-1:0] IPR_RESET_VIEW = 16'h4444;
   localparam logic [IPR_DATA_W-1:0] IPR_DATA_ZERO = 16'h0000;

endpackage

// >>> verilog/ipr_field_cell.sv
// One priority field with its request gate.
`timescale 1ns/1ps
module ipr_field_cell (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [ipr_pkg::IPR_FIELD_W-1:0] wr_field,
   input wire logic req_in,
   output logic [ipr_pkg::IPR_FIELD_W-1:0] level,
   output logic req_gated
);

   logic [ipr_pkg::IPR_FIELD_W-1:0] level_ff;
   logic gated_ff;

   // The field keeps its binary value as the priority level; reset gives level four.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         level_ff <= ipr_pkg::IPR_LEVEL_RESET;
      end else if (wr_en) begin
         level_ff <= wr_field;
      end
   end

   // A zero level blocks the request so it never reaches the processor.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gated_ff <= 1'b0;
      end else begin
         gated_ff <= req_in && (level_ff != ipr_pkg::IPR_LEVEL_OFF);
      end
   end

   assign level = level_ff;
   assign req_gated = gated_ff;

endmodule

// >>> verilog/ipr_priority_slice.sv
// Priority register slice for capture 8, capture 7, ADC2 done and external interrupt 1.
`timescale 1ns/1ps
module ipr_priority_slice #(
   parameter int unsigned ADDR_W = ipr_pkg::IPR_ADDR_W
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [ipr_pkg::IPR_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ipr_pkg::IPR_DATA_W-1:0] reg_rdata,
   input wire logic [ipr_pkg::IPR_NUM_FIELDS-1:0] src_req,
   output logic [ipr_pkg::IPR_NUM_FIELDS-1:0] src_req_gated,
   output logic [ipr_pkg::IPR_FIELD_W-1:0] capture8_irq_level,
   output logic [ipr_pkg::IPR_FIELD_W-1:0] capture7_irq_level,
   output logic [ipr_pkg::IPR_FIELD_W-1:0] adc2_done_irq_level,
   output logic [ipr_pkg::IPR_FIELD_W-1:0] ext_irq1_level
);

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------

   logic addr_hit;
   logic wr_hit;
   logic rd_hit;
   logic [ipr_pkg::IPR_FIELD_W-1:0] level_vec [ipr_pkg::IPR_NUM_FIELDS];
   logic [ipr_pkg::IPR_DATA_W-1:0] reg_view;
   logic [ipr_pkg::IPR_DATA_W-1:0] rdata_ff;
   logic [ipr_pkg::IPR_DATA_W-1:0] nxt_rdata;

   // Only the one word of this slice answers; other addresses read zero and ignore writes.
   assign addr_hit = (reg_addr == ADDR_W'(ipr_pkg::IPR_OFF_PRIORITY));
   assign wr_hit = reg_wr && addr_hit;
   assign rd_hit = reg_rd && addr_hit;

   // ----------------------------------------------------------------
   // Priority fields, one cell per source.
   // ----------------------------------------------------------------

   // Each cell takes its own three bits of the write word; the gap bits are never stored.
   for (genvar i = 0; i < ipr_pkg::IPR_NUM_FIELDS; i++) begin : g_field
      ipr_field_cell u_cell (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .wr_en(wr_hit),
         .wr_field(reg_wdata[i*ipr_pkg::IPR_FIELD_STRIDE +: ipr_pkg::IPR_FIELD_W]),
         .req_in(src_req[i]),
         .level(level_vec[i]),
         .req_gated(src_req_gated[i])
      );
   end

   // ----------------------------------------------------------------
   // Register view and level outputs.
   // ----------------------------------------------------------------

   // Unimplemented bits are tied low in the view, so a read never shows written ones.
   always_comb begin
      reg_view = ipr_pkg::IPR_DATA_ZERO;
      reg_view[ipr_pkg::IPR_LSB_CAPTURE8 +: ipr_pkg::IPR_FIELD_W] = level_vec[ipr_pkg::IPR_IDX_CAPTURE8];
      reg_view[ipr_pkg::IPR_LSB_CAPTURE7 +: ipr_pkg::IPR_FIELD_W] = level_vec[ipr_pkg::IPR_IDX_CAPTURE7];
      reg_view[ipr_pkg::IPR_LSB_ADC2 +: ipr_pkg::IPR_FIELD_W] = level_vec[ipr_pkg::IPR_IDX_ADC2];
      reg_view[ipr_pkg::IPR_LSB_EXT1 +: ipr_pkg::IPR_FIELD_W] = level_vec[ipr_pkg::IPR_IDX_EXT1];
   end

   // The levels go straight to the arbiter; they come from the field flip-flops.
   assign capture8_irq_level = level_vec[ipr_pkg::IPR_IDX_CAPTURE8];
   assign capture7_irq_level = level_vec[ipr_pkg::IPR_IDX_CAPTURE7];
   assign adc2_done_irq_level = level_vec[ipr_pkg::IPR_IDX_ADC2];
   assign ext_irq1_level = level_vec[ipr_pkg::IPR_IDX_EXT1];

   // ----------------------------------------------------------------
   // Read data.
   // ----------------------------------------------------------------

   // Read data stands only in the cycle after the strobe; zero at all other times.
   // A read in the same cycle as a write shows the old value, as the master never overlaps them.
   always_comb begin
      nxt_rdata = ipr_pkg::IPR_DATA_ZERO;
      if (rd_hit) begin
         nxt_rdata = reg_view & ipr_pkg::IPR_IMPL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdata_ff <= ipr_pkg::IPR_DATA_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   // Steps of a software access, used to build the checks below.
   sequence s_write_hit;
      reg_wr && addr_hit;
   endsequence

   sequence s_read_hit;
      reg_rd && addr_hit;
   endsequence

   // A write that turns the external interrupt 1 source off.
   sequence s_ext1_off_write;
      reg_wr && addr_hit && (reg_wdata[ipr_pkg::IPR_LSB_EXT1 +: ipr_pkg::IPR_FIELD_W] == ipr_pkg::IPR_LEVEL_OFF);
   endsequence

   // After a reset cycle every field shows level four.
   chk_reset_levels: assert property (
      disable iff (1'b0) !rst_b |=> (reg_view == ipr_pkg::IPR_RESET_VIEW)
   ) else $error("Priority fields did not reset to level four.");

   // A write to the slice lands in the capture 8 field in the next cycle.
   chk_capture8_write: assert property (
      s_write_hit |=> capture8_irq_level == $past(reg_wdata[ipr_pkg::IPR_LSB_CAPTURE8 +: ipr_pkg::IPR_FIELD_W])
   ) else $error("Capture 8 level does not follow bits 14 to 12.");

   // A write to the slice lands in the capture 7 field in the next cycle.
   chk_capture7_write: assert property (
      s_write_hit |=> capture7_irq_level == $past(reg_wdata[ipr_pkg::IPR_LSB_CAPTURE7 +: ipr_pkg::IPR_FIELD_W])
   ) else $error("Capture 7 level does not follow bits 10 to 8.");

   // A write to the slice lands in the external interrupt 1 field in the next cycle.
   chk_ext1_write: assert property (
      s_write_hit |=> ext_irq1_level == $past(reg_wdata[ipr_pkg::IPR_LSB_EXT1 +: ipr_pkg::IPR_FIELD_W])
   ) else $error("External interrupt 1 level does not follow bits 2 to 0.");

   // A write to the slice lands in the ADC2 field in the next cycle.
   chk_adc2_write: assert property (
      s_write_hit |=> adc2_done_irq_level == $past(reg_wdata[ipr_pkg::IPR_LSB_ADC2 +: ipr_pkg::IPR_FIELD_W])
   ) else $error("ADC2 level does not follow bits 6 to 4.");

   // Write then read gives back the written value with the gap bits cleared.
   chk_write_readback: assert property (
      s_write_hit ##1 (s_read_hit and !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & ipr_pkg::IPR_IMPL_MASK)
   ) else $error("Read back differs from the value written.");

   // Gap bits never read as one, whatever was written.
   chk_gap_bits_zero: assert property (
      (reg_rdata & ipr_pkg::IPR_UNIMPL_MASK) == ipr_pkg::IPR_DATA_ZERO
   ) else $error("An unimplemented bit read as one.");

   // Without a write to the slice the fields hold still.
   chk_fields_hold: assert property (
      !(reg_wr && addr_hit) |=> $stable(reg_view)
   ) else $error("Priority fields changed without a write.");

   // Read data appear only in the cycle after a read of the slice.
   chk_read_window: assert property (
      reg_rdata != ipr_pkg::IPR_DATA_ZERO |-> $past(reg_rd && addr_hit)
   ) else $error("Read data appeared without a read.");

   // A gated request needs a raised request and a non-zero level one cycle before.
   chk_disabled_gate: assert property (
      (src_req_gated & ~$past(src_req)) == '0 &&
      (!src_req_gated[ipr_pkg::IPR_IDX_CAPTURE8] || $past(capture8_irq_level) != ipr_pkg::IPR_LEVEL_OFF) &&
      (!src_req_gated[ipr_pkg::IPR_IDX_CAPTURE7] || $past(capture7_irq_level) != ipr_pkg::IPR_LEVEL_OFF) &&
      (!src_req_gated[ipr_pkg::IPR_IDX_ADC2] || $past(adc2_done_irq_level) != ipr_pkg::IPR_LEVEL_OFF) &&
      (!src_req_gated[ipr_pkg::IPR_IDX_EXT1] || $past(ext_irq1_level) != ipr_pkg::IPR_LEVEL_OFF)
   ) else $error("A request passed while its source was disabled.");

   // An enabled external interrupt 1 source with a request must pass it on in the next cycle.
   chk_enabled_pass: assert property (
      src_req[ipr_pkg::IPR_IDX_EXT1] && ext_irq1_level != ipr_pkg::IPR_LEVEL_OFF |=>
         src_req_gated[ipr_pkg::IPR_IDX_EXT1]
   ) else $error("An enabled request was dropped.");

   // The same pass-through holds for the capture 8 source.
   chk_capture8_pass: assert property (
      src_req[ipr_pkg::IPR_IDX_CAPTURE8] && capture8_irq_level != ipr_pkg::IPR_LEVEL_OFF |=>
         src_req_gated[ipr_pkg::IPR_IDX_CAPTURE8]
   ) else $error("An enabled capture 8 request was dropped.");

   // The same pass-through holds for the capture 7 source.
   chk_capture7_pass: assert property (
      src_req[ipr_pkg::IPR_IDX_CAPTURE7] && capture7_irq_level != ipr_pkg::IPR_LEVEL_OFF |=>
         src_req_gated[ipr_pkg::IPR_IDX_CAPTURE7]
   ) else $error("An enabled capture 7 request was dropped.");

   // The same pass-through holds for the ADC2 done source.
   chk_adc2_pass: assert property (
      src_req[ipr_pkg::IPR_IDX_ADC2] && adc2_done_irq_level != ipr_pkg::IPR_LEVEL_OFF |=>
         src_req_gated[ipr_pkg::IPR_IDX_ADC2]
   ) else $error("An enabled ADC2 request was dropped.");

   // Turning the external interrupt 1 source off must stop a request that arrives right after the write.
   chk_off_after_write: assert property (
      s_ext1_off_write ##1 src_req[ipr_pkg::IPR_IDX_EXT1] |=> !src_req_gated[ipr_pkg::IPR_IDX_EXT1]
   ) else $error("A request passed right after its source was turned off.");

   // Reset clears the read data and every gated request, so nothing stale leaks out.
   chk_reset_outputs: assert property (
      disable iff (1'b0) !rst_b |=> (reg_rdata == ipr_pkg::IPR_DATA_ZERO) && (src_req_gated == '0)
   ) else $error("Read data or a gated request survived reset.");

   // Without a read of the slice the read data fall back to zero in the next cycle.
   chk_read_idle: assert property (
      !(reg_rd && addr_hit) |=> reg_rdata == ipr_pkg::IPR_DATA_ZERO
   ) else $error("Read data stood longer than one cycle.");

   // A write to another address leaves every field alone; the slice owns one word only.
   chk_foreign_write: assert property (
      reg_wr && !addr_hit |=> $stable(reg_view)
   ) else $error("A write to another address changed a field.");

endmodule

// >>> dv/tb_irq_priority_slice_capture_adc_ext.sv
// Self-checking testbench for the capture, ADC and external interrupt priority register slice.
`timescale 1ns/1ps
module tb_irq_priority_slice_capture_adc_ext;

   // ----------------------------------------------------------------
   // Design connections, reference state and result queue.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] rdata;
      logic [15:0] view;
      logic [3:0] gate;
   } ipr_exp_t;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] src_req = 4'h0;
   logic [15:0] reg_rdata;
   logic [3:0] src_req_gated;
   logic [2:0] lvl8, lvl7, lvl_adc, lvl_ext;
   logic [15:0] shadow_ff = 16'h4444;
   logic [15:0] lfsr_ff = 16'h004c;
   ipr_exp_t note;
   ipr_exp_t due;
   ipr_exp_t exp_q[$];
   int errors = 0;
   int tests_run = 0;

   // The clock toggles every half period of 12.5 ns, a full period of 25 ns.
   always #12.5 core_clk = ~core_clk;

   ipr_priority_slice dut_u (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .src_req(src_req),
      .src_req_gated(src_req_gated),
      .capture8_irq_level(lvl8),
      .capture7_irq_level(lvl7),
      .adc2_done_irq_level(lvl_adc),
      .ext_irq1_level(lvl_ext)
   );

   // ----------------------------------------------------------------
   // Helpers: random source, live-field mask, compare and verdict.
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [3:0] live(input logic [15:0] v);
      return {|v[14:12], |v[10:8], |v[6:4], |v[2:0]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic summarize();
      if (errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One bus cycle; strobes last a single cycle and new random requests go out with it.
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      lfsr_ff = lfsr_next(lfsr_ff);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      src_req <= lfsr_ff[3:0];
   endtask

   // Reference model notes what each edge must produce; gating uses the level held before a write lands.
   always @(posedge core_clk) begin
      note.rdata = (reg_rd && reg_addr == ipr_pkg::IPR_OFF_PRIORITY) ?
         (shadow_ff & ipr_pkg::IPR_IMPL_MASK) : 16'h0000;
      note.gate = src_req & live(shadow_ff);
      if (!rst_b) begin
         shadow_ff = ipr_pkg::IPR_RESET_VIEW;
         note.rdata = 16'h0000;
         note.gate = 4'h0;
      end else if (reg_wr && reg_addr == ipr_pkg::IPR_OFF_PRIORITY) begin
         shadow_ff = reg_wdata & ipr_pkg::IPR_IMPL_MASK;
      end
      note.view = shadow_ff;
      exp_q.push_back(note);
   end

   // Outputs are compared on the falling edge, where every registered value has settled.
   always @(negedge core_clk) begin
      if (exp_q.size() > 0) begin
         due = exp_q.pop_front();
         check(reg_rdata, due.rdata);
         check({1'b0, lvl8, 1'b0, lvl7, 1'b0, lvl_adc, 1'b0, lvl_ext}, due.view);
         check({12'h000, src_req_gated}, {12'h000, due.gate});
      end
   end

   // A hang is cut short here and counted as a failure.
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      bus(1'b0, 1'b1, 8'h00, 16'h0000);
      bus(1'b1, 1'b0, 8'h00, 16'hffff);
      bus(1'b0, 1'b1, 8'h00, 16'h0000);
      // All sources off: no request may pass while levels are zero.
      bus(1'b1, 1'b0, 8'h00, 16'h0000);
      repeat (6) bus(1'b0, 1'b0, 8'h00, 16'h0000);
      bus(1'b0, 1'b1, 8'h00, 16'h0000);
      // Every code in every field, with the unused bits set high on purpose.
      for (int v = 0; v < 8; v++) begin
         bus(1'b1, 1'b0, 8'h00, {1'b1, 3'(v + 3), 1'b1, 3'(v + 2), 1'b1, 3'(v + 1), 1'b1, 3'(v)});
         bus(1'b0, 1'b1, 8'h00, 16'h0000);
      end
      // Random traffic, back to back, sometimes to unmapped addresses.
      repeat (80) begin
         bus(lfsr_ff[5:4] == 2'h1, lfsr_ff[5:4] == 2'h2, lfsr_ff[6] ? lfsr_ff[15:8] : 8'h00, lfsr_ff ^ 16'h5a5a);
      end
      bus(1'b1, 1'b0, 8'h01, 16'h0000);
      bus(1'b0, 1'b1, 8'h5a, 16'h0000);
      bus(1'b0, 1'b1, 8'h00, 16'h0000);
      // A second reset in mid-run must restore priority four everywhere.
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      rst_b <= 1'b0;
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      rst_b <= 1'b1;
      bus(1'b0, 1'b1, 8'h00, 16'h0000);
      repeat (2) bus(1'b0, 1'b0, 8'h00, 16'h0000);
      @(negedge core_clk);
      #1;
      summarize();
   end

endmodule
